// File: common/fault_regs_defs.svh
`ifndef FAULT_REGS_DEFS_SVH
`define FAULT_REGS_DEFS_SVH

`define CRN_FAULT_STATUS     4'h5
`define CRN_FAULT_ADDRESS    4'h6
`define CRN_CACHE_OPS        4'h7
`define CRM_PRIMARY          4'h0
`define CRM_AUX              4'h1
`define OP2_DATA             3'h0
`define OP2_INSTR            3'h1
`define OP2_IADDR            3'h2
`define CRM_PA_RESULT        4'h4
`define FS_QUAL_BIT          12
`define FS_HIGH_BIT          10
`define FS_L1_WALK_EXT       5'h0C
`define FS_L2_WALK_EXT       5'h0E
`define FS_TRANS_SECTION     5'h05
`define FS_TRANS_PAGE        5'h07
`define FS_FLAG_SECTION      5'h03
`define FS_FLAG_PAGE         5'h06
`define FS_DOMAIN_SECTION    5'h09
`define FS_DOMAIN_PAGE       5'h0B
`define FS_PERM_SECTION      5'h0D
`define FS_PERM_PAGE         5'h0F
`define FS_EXT_NONTRANS      5'h08
`define FS_DEBUG_EVENT       5'h02
`define RESET_WORD           32'h0000_0000
`define LINE_ADDR_LSB        5

`endif

// File: common/fault_regs_pkg.sv
package fault_regs_pkg;

    // one bit per fault source, index 0 is highest priority
    typedef enum logic [3:0] {
        SRC_L1_WALK_EXT,
        SRC_L2_WALK_EXT,
        SRC_TRANS_SECTION,
        SRC_TRANS_PAGE,
        SRC_FLAG_SECTION,
        SRC_FLAG_PAGE,
        SRC_DOMAIN_SECTION,
        SRC_DOMAIN_PAGE,
        SRC_PERM_SECTION,
        SRC_PERM_PAGE,
        SRC_EXT_NONTRANS,
        SRC_DEBUG_EVENT
    } fault_src_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        user_mode;
        logic        secure;
        logic [3:0]  crn;
        logic [3:0]  minor_register_select;
        logic [2:0]  op2;
        logic [31:0] wdata;
    } cop_req_t;

    typedef struct packed {
        logic        valid;
        logic        undefined;
        logic [31:0] rdata;
    } cop_resp_t;

    typedef struct packed {
        logic        valid;
        logic        secure;
        logic [11:0] sources;
        logic        slave_error;
        logic [31:0] address;
    } prefetch_abort_t;

    typedef struct packed {
        logic        valid;
        logic        secure;
        logic        synchronous;
        logic [31:0] address;
    } data_abort_t;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ICACHE_INVAL_ALL_SHARED,
        OP_PREDICTOR_INVAL_ALL_SHARED,
        OP_ICACHE_INVAL_ALL_UNIFY,
        OP_ICACHE_INVAL_LINE_ADDR,
        OP_INSTR_SYNC_BARRIER,
        OP_PREDICTOR_INVAL_ALL,
        OP_DCACHE_INVAL_LINE_ADDR,
        OP_DCACHE_INVAL_SETWAY,
        OP_DCACHE_CLEAN_ADDR_COHERENT,
        OP_DCACHE_CLEAN_SETWAY,
        OP_DCACHE_CLEAN_ADDR_UNIFY,
        OP_DCACHE_CLEAN_INVAL_ADDR,
        OP_DCACHE_CLEAN_INVAL_SETWAY,
        OP_DATA_SYNC_BARRIER,
        OP_DATA_MEMORY_BARRIER
    } maint_op_t;

    typedef struct packed {
        logic        valid;
        maint_op_t   op;
        logic        separate_only;
        logic        by_setway;
        logic [31:0] line_address;
        logic [31:0] way;
        logic [31:0] set;
    } maint_cmd_t;

endpackage : fault_regs_pkg

// File: verilog/fault_code_encoder.sv
`include "fault_regs_defs.svh"

module fault_code_encoder (
    input  wire logic [11:0] sources,
    input  wire logic        slave_error,
    output logic             any,
    output logic [12:0]      status
);
    import fault_regs_pkg::*;

    logic [4:0] code;

    // first set bit wins; unlisted codes are never produced
    always_comb begin
        code = 5'h00;
        any  = 1'b0;
        for (int i = 11; i >= 0; i--) begin
            if (sources[i]) begin
                any = 1'b1;
                case (fault_src_t'(i[3:0]))
                    SRC_L1_WALK_EXT:    code = `FS_L1_WALK_EXT;      // [R01]
                    SRC_L2_WALK_EXT:    code = `FS_L2_WALK_EXT;      // [R01]
                    SRC_TRANS_SECTION:  code = `FS_TRANS_SECTION;    // [R02]
                    SRC_TRANS_PAGE:     code = `FS_TRANS_PAGE;       // [R02]
                    SRC_FLAG_SECTION:   code = `FS_FLAG_SECTION;     // [R02]
                    SRC_FLAG_PAGE:      code = `FS_FLAG_PAGE;        // [R02]
                    SRC_DOMAIN_SECTION: code = `FS_DOMAIN_SECTION;   // [R02]
                    SRC_DOMAIN_PAGE:    code = `FS_DOMAIN_PAGE;      // [R02]
                    SRC_PERM_SECTION:   code = `FS_PERM_SECTION;     // [R02]
                    SRC_PERM_PAGE:      code = `FS_PERM_PAGE;        // [R02]
                    SRC_EXT_NONTRANS:   code = `FS_EXT_NONTRANS;     // [R03]
                    SRC_DEBUG_EVENT:    code = `FS_DEBUG_EVENT;      // [R03]
                    default:            code = 5'h00;
                endcase
            end
        end
    end

    logic is_external;
    assign is_external = (code == `FS_L1_WALK_EXT) || (code == `FS_L2_WALK_EXT) || (code == `FS_EXT_NONTRANS);

    // bit 12 qualifies external aborts only, bits 9:4 stay zero
    always_comb begin
        status = 13'h0000;
        status[`FS_QUAL_BIT] = is_external & slave_error;   // [R04] [R23]
        status[`FS_HIGH_BIT] = code[4];                      // [R05]
        status[3:0] = code[3:0];                             // [R25]
    end

endmodule : fault_code_encoder

// File: verilog/maint_op_decoder.sv
`include "fault_regs_defs.svh"

module maint_op_decoder #(
    parameter int WAY_BITS  = 2,
    parameter int LINE_BITS = 5,
    parameter int SET_BITS  = 8
) (
    input  wire logic [3:0]  minor_register_select,
    input  wire logic [2:0]  op2,
    input  wire logic [31:0] operand,
    output fault_regs_pkg::maint_op_t op,
    output logic             user_ok,
    output logic             by_setway,
    output logic [31:0]      line_address,
    output logic [31:0]      way,
    output logic [31:0]      set
);
    import fault_regs_pkg::*;

    always_comb begin
        op = OP_NONE;
        case ({minor_register_select, op2})
            {4'h1, 3'h0}: op = OP_ICACHE_INVAL_ALL_SHARED;       // [R17]
            {4'h1, 3'h6}: op = OP_PREDICTOR_INVAL_ALL_SHARED;    // [R17]
            {4'h5, 3'h0}: op = OP_ICACHE_INVAL_ALL_UNIFY;        // [R17]
            {4'h5, 3'h1}: op = OP_ICACHE_INVAL_LINE_ADDR;        // [R17]
            {4'h5, 3'h4}: op = OP_INSTR_SYNC_BARRIER;            // [R18]
            {4'h5, 3'h6}: op = OP_PREDICTOR_INVAL_ALL;           // [R17]
            {4'h6, 3'h1}: op = OP_DCACHE_INVAL_LINE_ADDR;        // [R19]
            {4'h6, 3'h2}: op = OP_DCACHE_INVAL_SETWAY;           // [R19]
            {4'hA, 3'h1}: op = OP_DCACHE_CLEAN_ADDR_COHERENT;    // [R19]
            {4'hA, 3'h2}: op = OP_DCACHE_CLEAN_SETWAY;           // [R19]
            {4'hA, 3'h4}: op = OP_DATA_SYNC_BARRIER;
            {4'hA, 3'h5}: op = OP_DATA_MEMORY_BARRIER;
            {4'hB, 3'h1}: op = OP_DCACHE_CLEAN_ADDR_UNIFY;       // [R19]
            {4'hE, 3'h1}: op = OP_DCACHE_CLEAN_INVAL_ADDR;       // [R19]
            {4'hE, 3'h2}: op = OP_DCACHE_CLEAN_INVAL_SETWAY;     // [R19]
            default:      op = OP_NONE;
        endcase
    end

    // only the barriers may run from user code
    assign user_ok = (op == OP_INSTR_SYNC_BARRIER) || (op == OP_DATA_SYNC_BARRIER)
                  || (op == OP_DATA_MEMORY_BARRIER);                                // [R16] [R18]

    assign by_setway = (op == OP_DCACHE_INVAL_SETWAY) || (op == OP_DCACHE_CLEAN_SETWAY)
                    || (op == OP_DCACHE_CLEAN_INVAL_SETWAY);

    // low five bits ignored for address operands
    assign line_address = {operand[31:`LINE_ADDR_LSB], 5'h00};                    // [R24]

    // should-be-zero bits are simply not looked at
    always_comb begin
        way = 32'h0000_0000;
        set = 32'h0000_0000;
        way[WAY_BITS-1:0] = operand[31 -: WAY_BITS];                               // [R21]
        set[SET_BITS-1:0] = operand[LINE_BITS +: SET_BITS];                        // [R21]
    end

endmodule : maint_op_decoder

// File: verilog/fault_record_cache_maint_regs.sv
// Functional notes
// [R01] walk external aborts encode 0x0C, 0x0E first
// [R02] translation, flag, domain, permission codes, section first
// [R03] external nontranslation, debug last; reserved never produced
// [R04] bit 12: decode error 0, slave error 1
// [R05] bit 10 high code bit; 9:4 zero
// [R06] route bit: secure data status on monitor entry
// [R07] c5 op2 1 reads/writes instruction status
// [R08] software writes zero into bits 31:4
// [R09] auxiliary status registers read zero, ignore writes
// [R10] banked per security state; user access undefined
// [R11] data address captures synchronous data faults only
// [R12] write loads data fault address
// [R13] debug entry updates data address in monitor mode
// [R14] instruction address captures prefetch abort; writable
// [R15] c7 reads undefined except address result
// [R16] c7 needs privilege except three barriers
// [R17] instruction cache and predictor operations decode
// [R18] c5/4 barrier flushes prefetch, user allowed
// [R19] data cache line operations decode
// [R20] unify invalidate touches separate instruction caches only
// [R21] set/way operand: way high, set above line
// [R22] newest prefetch abort overwrites instruction status
// [R23] bit 12 qualifies instruction external aborts
// [R24] address operand bits 31:5, low ignored
// [R25] only highest-priority fault recorded per access
`include "fault_regs_defs.svh"

module fault_record_cache_maint_regs #(
    parameter int WAY_BITS  = 2,
    parameter int LINE_BITS = 5,
    parameter int SET_BITS  = 8
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire fault_regs_pkg::cop_req_t        cop_req,
    output fault_regs_pkg::cop_resp_t            cop_resp,
    input  wire fault_regs_pkg::prefetch_abort_t prefetch_abort,
    input  wire fault_regs_pkg::data_abort_t     data_abort,
    input  wire logic                            external_abort_route,
    input  wire logic                            monitor_entry_ext_abort,
    input  wire logic [31:0]                     monitor_data_status,
    input  wire logic                            debug_entry,
    input  wire logic                            debug_monitor_mode,
    input  wire logic [31:0]                     debug_address,
    output fault_regs_pkg::maint_cmd_t           maint_cmd,
    output logic [31:0]                          secure_data_status
);
    import fault_regs_pkg::*;

    // index 0 non-secure, 1 secure
    logic [31:0] instr_fault_status  [2];
    logic [31:0] data_fault_address  [2];
    logic [31:0] instr_fault_address [2];

    logic        pf_any;
    logic [12:0] pf_status;

    fault_code_encoder u_encoder (
        .sources     (prefetch_abort.sources),
        .slave_error (prefetch_abort.slave_error),
        .any         (pf_any),
        .status      (pf_status)
    );

    maint_op_t   dec_op;
    logic        dec_user_ok;
    logic        dec_by_setway;
    logic [31:0] dec_line_address;
    logic [31:0] dec_way;
    logic [31:0] dec_set;

    maint_op_decoder #(
        .WAY_BITS  (WAY_BITS),
        .LINE_BITS (LINE_BITS),
        .SET_BITS  (SET_BITS)
    ) u_decoder (
        .minor_register_select          (cop_req.minor_register_select),
        .op2          (cop_req.op2),
        .operand      (cop_req.wdata),
        .op           (dec_op),
        .user_ok      (dec_user_ok),
        .by_setway    (dec_by_setway),
        .line_address (dec_line_address),
        .way          (dec_way),
        .set          (dec_set)
    );

    logic bank;
    assign bank = cop_req.secure;

    logic sel_istat;
    logic sel_aux;
    logic sel_daddr;
    logic sel_iaddr;
    logic sel_c7;
    logic sel_par;
    assign sel_istat = (cop_req.crn == `CRN_FAULT_STATUS) && (cop_req.minor_register_select == `CRM_PRIMARY)
                    && (cop_req.op2 == `OP2_INSTR);
    assign sel_aux   = (cop_req.crn == `CRN_FAULT_STATUS) && (cop_req.minor_register_select == `CRM_AUX)
                    && ((cop_req.op2 == `OP2_DATA) || (cop_req.op2 == `OP2_INSTR));
    assign sel_daddr = (cop_req.crn == `CRN_FAULT_ADDRESS) && (cop_req.minor_register_select == `CRM_PRIMARY)
                    && (cop_req.op2 == `OP2_DATA);
    assign sel_iaddr = (cop_req.crn == `CRN_FAULT_ADDRESS) && (cop_req.minor_register_select == `CRM_PRIMARY)
                    && (cop_req.op2 == `OP2_IADDR);
    assign sel_c7   = (cop_req.crn == `CRN_CACHE_OPS);
    // address result register lives in a neighbouring slice
    assign sel_par  = sel_c7 && (cop_req.minor_register_select == `CRM_PA_RESULT) && (cop_req.op2 == `OP2_DATA);

    logic fault_sel;
    assign fault_sel = sel_istat || sel_aux || sel_daddr || sel_iaddr;

    logic undef;
    always_comb begin
        undef = 1'b0;
        if (fault_sel && cop_req.user_mode) begin
            undef = 1'b1;                                           // [R10]
        end
        else if (sel_c7 && !cop_req.write && !sel_par) begin
            undef = 1'b1;                                           // [R15]
        end
        else if (sel_c7 && cop_req.write && cop_req.user_mode && !dec_user_ok) begin
            undef = 1'b1;                                           // [R16]
        end
    end

    logic wr_ok;
    assign wr_ok = cop_req.valid && cop_req.write && !undef;

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (sel_istat) begin
            next_rdata = instr_fault_status[bank];                  // [R07]
        end
        else if (sel_daddr) begin
            next_rdata = data_fault_address[bank];
        end
        else if (sel_iaddr) begin
            next_rdata = instr_fault_address[bank];
        end
        else if (sel_aux) begin
            next_rdata = 32'h0000_0000;                             // [R09]
        end
    end

    // one-cycle answer to every request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cop_resp <= '0;
        end
        else begin
            cop_resp.valid     <= cop_req.valid;
            cop_resp.undefined <= cop_req.valid && undef;
            cop_resp.rdata     <= (cop_req.valid && !cop_req.write && !undef) ? next_rdata : 32'h0000_0000;
        end
    end

    // software write and abort in one cycle: the abort wins, it is newer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instr_fault_status[0] <= `RESET_WORD;
            instr_fault_status[1] <= `RESET_WORD;
        end
        else begin
            if (wr_ok && sel_istat) begin
                instr_fault_status[bank] <= cop_req.wdata;          // [R07] [R08]
            end
            if (prefetch_abort.valid && pf_any) begin
                instr_fault_status[prefetch_abort.secure] <= {19'h00000, pf_status};  // [R22] [R25]
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instr_fault_address[0] <= `RESET_WORD;
            instr_fault_address[1] <= `RESET_WORD;
        end
        else begin
            if (wr_ok && sel_iaddr) begin
                instr_fault_address[bank] <= cop_req.wdata;         // [R14]
            end
            if (prefetch_abort.valid && pf_any) begin
                instr_fault_address[prefetch_abort.secure] <= prefetch_abort.address;  // [R14] [R25]
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_fault_address[0] <= `RESET_WORD;
            data_fault_address[1] <= `RESET_WORD;
        end
        else begin
            if (wr_ok && sel_daddr) begin
                data_fault_address[bank] <= cop_req.wdata;          // [R12]
            end
            // halting debug leaves the register for the debugger to read
            if (debug_entry && debug_monitor_mode) begin
                data_fault_address[bank] <= debug_address;          // [R13]
            end
            if (data_abort.valid && data_abort.synchronous) begin
                data_fault_address[data_abort.secure] <= data_abort.address;  // [R11]
            end
        end
    end

    // secure data status copy driven by monitor entry
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            secure_data_status <= `RESET_WORD;
        end
        else if (external_abort_route && monitor_entry_ext_abort) begin
            secure_data_status <= monitor_data_status;              // [R06]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            maint_cmd <= '0;
        end
        else begin
            maint_cmd.valid         <= wr_ok && sel_c7 && (dec_op != OP_NONE);
            maint_cmd.op            <= dec_op;
            maint_cmd.separate_only <= (dec_op == OP_ICACHE_INVAL_ALL_UNIFY);  // [R20]
            maint_cmd.by_setway     <= dec_by_setway;
            maint_cmd.line_address  <= dec_line_address;            // [R24]
            maint_cmd.way           <= dec_way;                     // [R21]
            maint_cmd.set           <= dec_set;                     // [R21]
        end
    end

endmodule : fault_record_cache_maint_regs

// File: bench/fault_regs_sva.sv
module fault_regs_sva #(
    parameter int WAY_BITS  = 2,
    parameter int LINE_BITS = 5,
    parameter int SET_BITS  = 8
) (
    input wire logic                       ref_clk,
    input wire logic                       rst,
    input wire fault_regs_pkg::cop_req_t   cop_req,
    input wire fault_regs_pkg::cop_resp_t  cop_resp,
    input wire fault_regs_pkg::maint_cmd_t maint_cmd
);
    timeunit 1ns;
    timeprecision 100ps;
    import fault_regs_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic c7_write;
    logic c7_user_op;
    assign c7_write   = cop_req.valid && cop_req.write && cop_req.crn == 4'h7;
    assign c7_user_op = (cop_req.minor_register_select == 4'h5 && cop_req.op2 == 3'h4)
                        || (cop_req.minor_register_select == 4'hA && (cop_req.op2 == 3'h4 || cop_req.op2 == 3'h5));

    chk_resp_next_cycle: assert property (
        cop_req.valid |=> cop_resp.valid) else $error("no response");
    chk_resp_no_extra: assert property (
        !cop_req.valid |=> !cop_resp.valid && !maint_cmd.valid) else $error("stray response");
    chk_user_fault_regs: assert property (
        cop_req.valid && cop_req.user_mode && (cop_req.crn == 4'h5 || cop_req.crn == 4'h6)
        |=> cop_resp.undefined && cop_resp.rdata == 32'h0) else $error("user access taken");
    chk_c7_read_undef: assert property (
        cop_req.valid && !cop_req.write && cop_req.crn == 4'h7 && !(cop_req.minor_register_select == 4'h4 && cop_req.op2 == 3'h0)
        |=> cop_resp.undefined) else $error("c7 read taken");
    chk_aux_reads_zero: assert property (
        cop_req.valid && !cop_req.write && !cop_req.user_mode && cop_req.crn == 4'h5 && cop_req.minor_register_select == 4'h1
        && cop_req.op2 < 3'h2 |=> !cop_resp.undefined && cop_resp.rdata == 32'h0) else $error("aux status not zero");
    chk_user_c7_refused: assert property (
        c7_write && cop_req.user_mode && !c7_user_op
        |=> cop_resp.undefined && !maint_cmd.valid) else $error("user c7 op taken");
    chk_barrier_user: assert property (
        c7_write && cop_req.user_mode && cop_req.minor_register_select == 4'h5 && cop_req.op2 == 3'h4
        |=> !cop_resp.undefined && maint_cmd.valid && maint_cmd.op == OP_INSTR_SYNC_BARRIER)
        else $error("user barrier refused");
    chk_maint_cause: assert property (
        maint_cmd.valid |-> $past(c7_write)) else $error("stray command");
    chk_line_low_zero: assert property (
        maint_cmd.valid |-> maint_cmd.line_address[4:0] == 5'h00) else $error("line low bits");
    chk_setway_way: assert property (
        maint_cmd.valid && maint_cmd.by_setway |-> maint_cmd.way == ($past(cop_req.wdata) >> (32 - WAY_BITS)))
        else $error("way index wrong");
    chk_setway_set: assert property (
        maint_cmd.valid && maint_cmd.by_setway
        |-> maint_cmd.set == (($past(cop_req.wdata) >> LINE_BITS) & ((32'h1 << SET_BITS) - 32'h1)))
        else $error("set index wrong");
    chk_unify_separate: assert property (
        maint_cmd.valid |-> maint_cmd.separate_only == (maint_cmd.op == OP_ICACHE_INVAL_ALL_UNIFY))
        else $error("separate flag");

    cover property (maint_cmd.valid && maint_cmd.by_setway);
    cover property (cop_req.valid && cop_req.user_mode ##1 cop_resp.undefined);
    cover property (maint_cmd.valid && maint_cmd.op == OP_DATA_MEMORY_BARRIER);
endmodule : fault_regs_sva

bind fault_record_cache_maint_regs fault_regs_sva #(
    .WAY_BITS(WAY_BITS), .LINE_BITS(LINE_BITS), .SET_BITS(SET_BITS)
) i_fault_regs_sva (
    .ref_clk(ref_clk), .rst(rst), .cop_req(cop_req), .cop_resp(cop_resp), .maint_cmd(maint_cmd)
);

// File: bench/core_pipe_model.sv
module core_pipe_model (
    input  wire logic                      ref_clk,
    output fault_regs_pkg::cop_req_t       cop_req,
    input  wire fault_regs_pkg::cop_resp_t cop_resp
);
    timeunit 1ns;
    timeprecision 100ps;
    import fault_regs_pkg::*;

    initial cop_req = '0;

    function automatic logic [31:0] setway(input logic [1:0] way, input logic [7:0] set);
        return {way, 17'h0, set, 5'h00};
    endfunction : setway

    // sel packs crn, crm, op2
    task automatic access(input logic wr, user, sec, input logic [10:0] sel, input logic [31:0] wd,
                          output cop_resp_t resp);
        cop_req_t req;
        req = {1'b1, wr, user, sec, sel, wd};
        if (wr && sel == 11'h281) begin
            req.wdata[31:4] = 28'h0;
        end
        @(posedge ref_clk);
        cop_req <= req;
        @(posedge ref_clk);
        // invert stale fields, keep bank
        req = ~req;
        req.valid = 1'b0;
        req.secure = sec;
        cop_req <= req;
        #1;
        resp = cop_resp;
    endtask : access
endmodule : core_pipe_model

// File: bench/fault_record_cache_maint_regs_test.sv
module fault_record_cache_maint_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    import fault_regs_pkg::*;

    logic            ref_clk;
    logic            rst;
    cop_req_t        cop_req;
    cop_resp_t       cop_resp;
    cop_resp_t       resp;
    prefetch_abort_t prefetch_abort;
    data_abort_t     data_abort;
    maint_cmd_t      maint_cmd;
    logic            external_abort_route;
    logic            monitor_entry_ext_abort;
    logic            debug_entry;
    logic            debug_monitor_mode;
    logic [31:0]     monitor_data_status;
    logic [31:0]     debug_address;
    logic [31:0]     secure_data_status;
    int              fails;
    int              check_count;
    logic [4:0]      fs_code [12] = '{5'h0C, 5'h0E, 5'h05, 5'h07, 5'h03, 5'h06,
                                      5'h09, 5'h0B, 5'h0D, 5'h0F, 5'h08, 5'h02};
    // {crm, op2}
    logic [6:0]      c7_sel [15] = '{7'h08, 7'h0E, 7'h28, 7'h29, 7'h2C, 7'h2E, 7'h31, 7'h32,
                                     7'h51, 7'h52, 7'h59, 7'h71, 7'h72, 7'h54, 7'h55};

    fault_record_cache_maint_regs i_fault_record_cache_maint_regs (.*);

    core_pipe_model i_core_pipe_model (.*);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic acc(input logic wr, user, sec, input logic [10:0] sel, input logic [31:0] wd);
        i_core_pipe_model.access(wr, user, sec, sel, wd, resp);
    endtask : acc

    task automatic rd(input logic user, sec, input logic [10:0] sel, input logic [31:0] exp, input logic undef);
        acc(1'b0, user, sec, sel, 32'h0);
        check({31'h0, resp.undefined}, {31'h0, undef}, "undef");
        check(resp.rdata, exp, "rdata");
    endtask : rd

    task automatic pabort(input logic sec, input logic [11:0] src, input logic slv, input logic [31:0] addr);
        @(posedge ref_clk);
        prefetch_abort <= '{1'b1, sec, src, slv, addr};
        @(posedge ref_clk);
        prefetch_abort.valid <= 1'b0;
    endtask : pabort

    // kind: 0 abort, 1 debug, 2 monitor
    task automatic pulse(input int kind, input logic flag, input logic [31:0] val);
        @(posedge ref_clk);
        data_abort <= '{kind == 0, 1'b0, flag, val};
        debug_entry <= kind == 1;
        debug_monitor_mode <= flag;
        debug_address <= val;
        monitor_entry_ext_abort <= kind == 2;
        external_abort_route <= flag;
        monitor_data_status <= val;
        @(posedge ref_clk);
        data_abort.valid <= 1'b0;
        debug_entry <= 1'b0;
        monitor_entry_ext_abort <= 1'b0;
        #1;
    endtask : pulse

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    initial begin
        #200us;
        fails++;
        results;
    end

    initial begin
        logic ext;
        logic is_sw;
        logic [31:0] wd;
        rst = 1'b1;
        prefetch_abort = '0;
        data_abort = '0;
        {external_abort_route, monitor_entry_ext_abort, debug_entry, debug_monitor_mode} = 4'h0;
        {monitor_data_status, debug_address} = 64'h0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            rd(1'b0, s[0], 11'h281, 32'h0, 1'b0);
            rd(1'b0, s[0], 11'h300, 32'h0, 1'b0);
            rd(1'b0, s[0], 11'h302, 32'h0, 1'b0);
            acc(1'b1, 1'b0, s[0], 11'h300, 32'hA5A5_0000 | 32'(s));
            acc(1'b1, 1'b0, s[0], 11'h302, 32'h5A5A_0000 | 32'(s));
            acc(1'b1, 1'b0, s[0], 11'h281, 32'hFFFF_FFF0 | 32'(s));
        end
        for (int s = 0; s < 2; s++) begin
            rd(1'b0, s[0], 11'h300, 32'hA5A5_0000 | 32'(s), 1'b0);
            rd(1'b0, s[0], 11'h302, 32'h5A5A_0000 | 32'(s), 1'b0);
            rd(1'b0, s[0], 11'h281, 32'(s), 1'b0);
        end
        $display("test register access done");
        acc(1'b1, 1'b1, 1'b0, 11'h300, 32'h1234_5678);
        check({31'h0, resp.undefined}, 32'h1, "user write");
        rd(1'b1, 1'b0, 11'h281, 32'h0, 1'b1);
        rd(1'b0, 1'b0, 11'h300, 32'hA5A5_0000, 1'b0);
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, 1'b0, 1'b0, {8'h51, k[2:0]}, 32'hFFFF_FFFF);
            rd(1'b0, 1'b0, {8'h51, k[2:0]}, 32'h0, 1'b0);
            rd(1'b1, 1'b1, {8'h51, k[2:0]}, 32'h0, 1'b1);
        end
        $display("test privilege done");
        for (int i = 0; i < 12; i++) begin
            ext = i < 2 || i == 10;
            pabort(i[0], 12'hFFF << i, 1'b1, 32'h4000_0000 | 32'(i << 5));
            rd(1'b0, i[0], 11'h281, {19'h0, ext, 1'b0, fs_code[i][4], 6'h00, fs_code[i][3:0]}, 1'b0);
            rd(1'b0, i[0], 11'h302, 32'h4000_0000 | 32'(i << 5), 1'b0);
        end
        pabort(1'b0, 12'h401, 1'b0, 32'h0000_1000);
        rd(1'b0, 1'b0, 11'h281, 32'h0000_000C, 1'b0);
        rd(1'b0, 1'b0, 11'h300, 32'hA5A5_0000, 1'b0);
        $display("test prefetch abort done");
        pulse(0, 1'b1, 32'hC000_0040);
        pulse(0, 1'b0, 32'hDEAD_0000);
        rd(1'b0, 1'b0, 11'h300, 32'hC000_0040, 1'b0);
        pulse(1, 1'b1, 32'h0BAD_0F00);
        rd(1'b0, 1'b0, 11'h300, 32'h0BAD_0F00, 1'b0);
        pulse(1, 1'b0, 32'h1111_2222);
        rd(1'b0, 1'b0, 11'h300, 32'h0BAD_0F00, 1'b0);
        pulse(2, 1'b0, 32'h0000_1008);
        check(secure_data_status, 32'h0, "no route");
        pulse(2, 1'b1, 32'h0000_1008);
        check(secure_data_status, 32'h0000_1008, "route");
        $display("test data abort done");
        for (int k = 0; k < 15; k++) begin
            is_sw = k == 7 || k == 9 || k == 12;
            wd = is_sw ? i_core_pipe_model.setway(2'h3, 8'h52) : 32'hC000_0A5F;
            acc(1'b1, 1'b0, 1'b0, {4'h7, c7_sel[k]}, wd);
            check({maint_cmd.valid, maint_cmd.by_setway, maint_cmd.separate_only, 25'h0, maint_cmd.op},
                  {1'b1, is_sw, k == 2, 25'h0, 4'(k + 1)}, "maint");
            if (is_sw) check(maint_cmd.way ^ (maint_cmd.set << 4), 32'h3 ^ 32'h520, "setway");
            if (k == 3 || k == 6 || k == 8 || k == 10 || k == 11) check(maint_cmd.line_address, 32'hC000_0A40, "line");
            acc(1'b1, 1'b1, 1'b0, {4'h7, c7_sel[k]}, wd);
            check({30'h0, resp.undefined, maint_cmd.valid}, (k == 4 || k > 12) ? 32'h1 : 32'h2, "user op");
            rd(1'b0, 1'b0, {4'h7, c7_sel[k]}, 32'h0, 1'b1);
        end
        rd(1'b0, 1'b0, 11'h3A0, 32'h0, 1'b0);
        $display("test cache operations done");
        results;
    end
endmodule : fault_record_cache_maint_regs_test
